//--- src/ibtq_pkg.sv
// Shared constants and types for the image block transfer queue.
// Assumes an APB register bus with 32-bit data and a byte address.
package ibtq_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BLOCKS = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_CAPACITY = 8'h0C;
    localparam logic [7:0] ADDR_OCCUPANCY = 8'h10;
    localparam logic [7:0] ADDR_DROPPED = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // ------------------------------------------------------------
    // Field positions and encodings
    // ------------------------------------------------------------
    localparam int CTRL_METHOD_LSB = 0;
    localparam int CTRL_STYLE_BIT = 2;
    localparam int CTRL_ORDER_BIT = 3;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_HALT_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_GATE_BIT = 1;
    localparam int STAT_LEFT_LSB = 16;
    localparam logic [1:0] METHOD_BASIC = 2'h0;
    localparam logic [1:0] METHOD_AUTOMATIC = 2'h1;
    localparam logic [1:0] HOST_DRIVEN_METHOD = 2'h2;
    localparam logic CONTINUOUS_STYLE = 1'h0;
    localparam logic COUNTED_BURST_STYLE = 1'h1;
    localparam logic OLDEST_FIRST_ORDER = 1'h0;
    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int QUEUE_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam int ID_W = 16;
    localparam logic [CNT_W-1:0] QUEUE_FULL_CNT = 4'h8;
    localparam logic [1:0] RST_METHOD = METHOD_BASIC;
    localparam logic [ID_W-1:0] RST_BLOCKS = 16'h0001;
    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {ST_IDLE, ST_SEND} ibtq_st_t;
    typedef struct packed {
        logic [QUEUE_DEPTH-1:0][ID_W-1:0] mem;
        logic [PTR_W-1:0] rd;
        logic [PTR_W-1:0] wr;
        logic [CNT_W-1:0] cnt;
    } ibtq_fifo_t;
    typedef struct packed {
        ibtq_st_t st;
        logic [1:0] method;
        logic style;
        logic [ID_W-1:0] blocks;
        logic gate;
        logic [ID_W-1:0] left;
        logic [31:0] dropped;
        logic busy;
        logic [ID_W-1:0] tx_id;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ibtq_state_t;
endpackage

//--- src/ibtq_fifo.sv
// Block descriptor queue, oldest first, overwriting the oldest when full.
// Assumes the caller pops only when count is non-zero and sees ovf at once.
`timescale 1ns/1ns
module ibtq_fifo import ibtq_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill and drain
    input wire logic push,
    input wire logic [ID_W-1:0] push_id,
    input wire logic pop,
    input wire logic flush,
    // Status
    output logic [ID_W-1:0] head_id,
    output logic [CNT_W-1:0] count,
    output logic ovf
);
    ibtq_fifo_t s_reg, s_next;
    logic popped;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        ovf = 1'b0;
        popped = pop && (s_reg.cnt != '0);
        if (flush) begin
            s_next.rd = '0;
            s_next.wr = '0;
            s_next.cnt = '0;
        end else begin
            if (popped) begin
                s_next.rd = PTR_W'(s_reg.rd + 1'b1);
                s_next.cnt = CNT_W'(s_reg.cnt - 1'b1);
            end
            if (push) begin
                s_next.mem[s_reg.wr] = push_id;
                s_next.wr = PTR_W'(s_reg.wr + 1'b1);
                if (s_reg.cnt == QUEUE_FULL_CNT && !popped) begin
                    // In-flight block already left the queue, so only queued ones drop
                    s_next.rd = PTR_W'(s_reg.rd + 1'b1);
                    ovf = 1'b1;
                end else begin
                    s_next.cnt = CNT_W'(s_next.cnt + 1'b1);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign head_id = s_reg.mem[s_reg.rd];
    assign count = s_reg.cnt;

    property p_full_stays_full;
        @(posedge pclk) disable iff (!presetn)
        (count == QUEUE_FULL_CNT && push && !pop && !flush) |=> count == QUEUE_FULL_CNT && $past(ovf);
    endproperty
    a_full_stays_full: assert property (p_full_stays_full) else $error("full queue push lost capacity");
endmodule // ibtq_fifo

//--- src/ibtq_top.sv
// Image block transfer queue with APB registers and stream channel hand-off.
// Assumes a descriptor arrives once a link packet's worth of its block is ready,
// and the transmitter pulses tx_done when a whole block has left.
//
// Overview of operation
// - In basic and automatic methods a block starts once one link packet of it is ready.
// - In the host-driven method blocks go out only as the go and halt commands allow.
// - Host-driven continuous style streams freely while go and halt gate it, acquisition aside.
// - Counted burst style sends exactly the programmed number of blocks after go, then stops; a go in the cycle a block starts keeps the old count less one.
// - A read-write setting holds the number of blocks to send in counted burst style.
// - That setting is ignored unless counted burst style is selected.
// - A read-only value gives the queue capacity in blocks.
// - A read-only value gives the number of blocks now queued.
// - A read-only tally counts blocks dropped because the queue overflowed.
// - The queue ordering offers oldest-first only and the queue works that way.
// - Writing go starts streaming blocks out on the stream channel.
// - Halt lets the block in progress finish before streaming stops.
// - A block arriving at a full queue overwrites the oldest queued one and bumps the tally.
// - The oldest queued block is always the next one sent.
// - Acquisition has no effect on the queue, but closing the channel flushes it and all pending sends.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module ibtq_top import ibtq_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // Processed blocks in
    input wire logic blk_in_valid,
    input wire logic [ID_W-1:0] blk_in_id,
    // Stream channel
    input wire logic chan_open,
    input wire logic tx_done,
    output logic tx_busy,
    output logic [ID_W-1:0] tx_id
);
    ibtq_state_t s_reg, s_next;
    logic [ID_W-1:0] q_head;
    logic [CNT_W-1:0] q_count;
    logic q_ovf;
    logic q_pop;
    logic acc;
    logic wr_fire;
    logic go_cmd;
    logic halt_cmd;
    logic may_start;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic addr_ok(input logic [7:0] a, input logic w);
        case (a)
            ADDR_CTRL, ADDR_BLOCKS: addr_ok = 1'b1;
            ADDR_CMD: addr_ok = w;
            ADDR_CAPACITY, ADDR_OCCUPANCY, ADDR_DROPPED, ADDR_STATUS: addr_ok = !w;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] rd_word(input ibtq_state_t s, input logic [7:0] a,
                                            input logic [CNT_W-1:0] occ);
        rd_word = '0;
        case (a)
            ADDR_CTRL: begin
                rd_word[CTRL_METHOD_LSB +: 2] = s.method;
                rd_word[CTRL_STYLE_BIT] = s.style;
                rd_word[CTRL_ORDER_BIT] = OLDEST_FIRST_ORDER;
            end
            ADDR_BLOCKS: rd_word[ID_W-1:0] = s.blocks;
            ADDR_CAPACITY: rd_word[CNT_W-1:0] = QUEUE_FULL_CNT;
            ADDR_OCCUPANCY: rd_word[CNT_W-1:0] = occ;
            ADDR_DROPPED: rd_word = s.dropped;
            ADDR_STATUS: begin
                rd_word[STAT_BUSY_BIT] = s.busy;
                rd_word[STAT_GATE_BIT] = s.gate;
                rd_word[STAT_LEFT_LSB +: ID_W] = s.left;
            end
            default: rd_word = '0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Queue
    // ------------------------------------------------------------
    ibtq_fifo u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .push(blk_in_valid),
        .push_id(blk_in_id),
        .pop(q_pop),
        .flush(!chan_open),
        .head_id(q_head),
        .count(q_count),
        .ovf(q_ovf)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        s_next.prdata = '0;
        q_pop = 1'b0;
        acc = psel && penable;
        // One wait state keeps all APB outputs straight from flops
        wr_fire = acc && s_reg.pready && pwrite && addr_ok(paddr, pwrite);
        // Commands only act under the host-driven method
        go_cmd = wr_fire && paddr == ADDR_CMD && pwdata[CMD_GO_BIT] && s_reg.method == HOST_DRIVEN_METHOD;
        halt_cmd = wr_fire && paddr == ADDR_CMD && pwdata[CMD_HALT_BIT] && s_reg.method == HOST_DRIVEN_METHOD;
        if (s_reg.method != HOST_DRIVEN_METHOD) begin
            may_start = 1'b1;
        end else begin
            may_start = s_reg.gate;
        end

        if (acc && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.pslverr = !addr_ok(paddr, pwrite);
            if (!pwrite) begin
                s_next.prdata = rd_word(s_reg, paddr, q_count);
            end
        end

        if (wr_fire && paddr == ADDR_CTRL) begin
            if (pwdata[CTRL_METHOD_LSB +: 2] != 2'h3) begin
                s_next.method = pwdata[CTRL_METHOD_LSB +: 2];
            end
            s_next.style = pwdata[CTRL_STYLE_BIT];
        end
        if (wr_fire && paddr == ADDR_BLOCKS) begin
            s_next.blocks = pwdata[ID_W-1:0];
        end

        if (go_cmd) begin
            s_next.gate = 1'b1;
            if (s_reg.style == COUNTED_BURST_STYLE) begin
                s_next.left = s_reg.blocks;
                s_next.gate = s_reg.blocks != '0;
            end
        end
        if (halt_cmd) begin
            s_next.gate = 1'b0;
        end

        if (q_ovf) begin
            s_next.dropped = s_reg.dropped + 32'h00000001;
        end

        case (s_reg.st)
            ST_IDLE: begin
                if (chan_open && q_count != '0 && may_start) begin
                    q_pop = 1'b1;
                    s_next.tx_id = q_head;
                    s_next.busy = 1'b1;
                    s_next.st = ST_SEND;
                    if (s_reg.method == HOST_DRIVEN_METHOD && s_reg.style == COUNTED_BURST_STYLE) begin
                        s_next.left = ID_W'(s_reg.left - 1'b1);
                        if (s_reg.left == 16'h0001 && !go_cmd) begin
                            s_next.gate = 1'b0;
                        end
                    end
                end
            end
            ST_SEND: begin
                // Halt never cuts a block short; only tx_done or closing ends it
                if (tx_done) begin
                    s_next.busy = 1'b0;
                    s_next.st = ST_IDLE;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
                s_next.busy = 1'b0;
            end
        endcase

        if (!chan_open) begin
            s_next.st = ST_IDLE;
            s_next.busy = 1'b0;
            s_next.gate = 1'b0;
            s_next.left = '0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{st: ST_IDLE, method: RST_METHOD, style: CONTINUOUS_STYLE, blocks: RST_BLOCKS,
                       gate: 1'b0, left: '0, dropped: '0, busy: 1'b0, tx_id: '0,
                       pready: 1'b0, pslverr: 1'b0, prdata: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign prdata = s_reg.prdata;
    assign tx_busy = s_reg.busy;
    assign tx_id = s_reg.tx_id;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_block_open;
        !tx_busy ##1 tx_busy;
    endsequence

    property p_auto_starts;
        @(posedge pclk) disable iff (!presetn)
        (s_reg.method != HOST_DRIVEN_METHOD && !tx_busy && q_count != '0 && chan_open) |=> tx_busy;
    endproperty
    a_auto_starts: assert property (p_auto_starts) else $error("auto method did not start");

    property p_gate_closed_idle;
        @(posedge pclk) disable iff (!presetn)
        (s_reg.method == HOST_DRIVEN_METHOD && !s_reg.gate && !tx_busy) |=> !tx_busy;
    endproperty
    a_gate_closed_idle: assert property (p_gate_closed_idle) else $error("sent while halted");

    property p_go_opens;
        @(posedge pclk) disable iff (!presetn)
        (go_cmd && !halt_cmd && s_reg.style == CONTINUOUS_STYLE && chan_open) |=> s_reg.gate;
    endproperty
    a_go_opens: assert property (p_go_opens) else $error("go did not open the gate");

    property p_last_of_burst;
        @(posedge pclk) disable iff (!presetn)
        (q_pop && s_reg.style == COUNTED_BURST_STYLE && s_reg.method == HOST_DRIVEN_METHOD
         && s_reg.left == 16'h0001 && !go_cmd) |=> !s_reg.gate && s_reg.left == '0;
    endproperty
    a_last_of_burst: assert property (p_last_of_burst) else $error("burst did not stop");

    property p_no_truncate;
        @(posedge pclk) disable iff (!presetn)
        (tx_busy && !tx_done && chan_open) |=> tx_busy && $stable(tx_id);
    endproperty
    a_no_truncate: assert property (p_no_truncate) else $error("block cut short");

    property p_oldest_sent;
        @(posedge pclk) disable iff (!presetn)
        s_block_open |-> tx_id == $past(q_head);
    endproperty
    a_oldest_sent: assert property (p_oldest_sent) else $error("not oldest block");

    property p_drop_tally;
        @(posedge pclk) disable iff (!presetn)
        q_ovf |=> s_reg.dropped == $past(s_reg.dropped) + 32'h00000001;
    endproperty
    a_drop_tally: assert property (p_drop_tally) else $error("drop not counted");

    property p_close_flushes;
        @(posedge pclk) disable iff (!presetn)
        !chan_open |=> q_count == '0 && !tx_busy && !s_reg.gate;
    endproperty
    a_close_flushes: assert property (p_close_flushes) else $error("close did not flush");

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");
endmodule // ibtq_top

//--- verif/ibtq_tx_model.sv
// Stream channel transmitter model: sends the block in flight and reports when it is done.
// Assumes tx_busy and tx_id come from registers and tx_done is read at the next rising edge.
`timescale 1ns/1ns
module ibtq_tx_model import ibtq_pkg::*; #(
    parameter int LAT = 3
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Block side
    input wire logic tx_busy,
    input wire logic [ID_W-1:0] tx_id,
    input wire logic hold,
    output logic tx_done
);
    // ------------------------------------------------------------
    // Send timer
    // ------------------------------------------------------------
    int cnt;
    // Hold stands in for a slow link, so the queue can fill up behind it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (tx_busy && !tx_done && !hold) begin
                if (cnt == LAT) begin
                    tx_done <= 1'b1;
                    cnt <= 0;
                end else begin
                    cnt <= cnt + 1;
                end
            end else if (!tx_busy) begin
                cnt <= 0;
            end
        end
    end
endmodule // ibtq_tx_model

//--- verif/test_image_block_transfer_queue.sv
// Self-checking bench for the transfer queue: APB master, block source and transmitter model.
// Assumes the package register map and a one-wait-state APB slave.
`timescale 1ns/1ns
module test_image_block_transfer_queue import ibtq_pkg::*;;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic pready, pslverr, tx_busy, tx_done, busy_q;
    logic [31:0] prdata, rdata;
    logic rerr;
    logic blk_in_valid;
    logic [ID_W-1:0] blk_in_id;
    logic chan_open;
    logic hold;
    logic [ID_W-1:0] tx_id;
    logic [ID_W-1:0] sent[$];
    logic [ID_W-1:0] exp[$];
    int bad_count = 0;
    int n_tests = 0;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} ibtq_row_t;
    ibtq_row_t rows[8] = '{'{ADDR_CTRL, 32'h0, 1'b0}, '{ADDR_BLOCKS, 32'h1, 1'b0},
        '{ADDR_CAPACITY, 32'h8, 1'b0}, '{ADDR_OCCUPANCY, 32'h0, 1'b0}, '{ADDR_DROPPED, 32'h0, 1'b0},
        '{ADDR_STATUS, 32'h0, 1'b0}, '{ADDR_CMD, 32'h0, 1'b1}, '{8'h1C, 32'h0, 1'b1}};

    always #50 pclk = ~pclk;

    ibtq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .blk_in_valid(blk_in_valid), .blk_in_id(blk_in_id), .chan_open(chan_open), .tx_done(tx_done),
        .tx_busy(tx_busy), .tx_id(tx_id));
    ibtq_tx_model #(.LAT(3)) link (.pclk(pclk), .presetn(presetn), .tx_busy(tx_busy), .tx_id(tx_id),
        .hold(hold), .tx_done(tx_done));

    // Record every block as it starts, so order checks see the wire
    always @(posedge pclk) begin
        if (tx_busy === 1'b1 && busy_q !== 1'b1)
            sent.push_back(tx_id);
        busy_q <= tx_busy;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit here; a missing answer is left to the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk(rdata, want);
    endtask

    task automatic push(input logic [ID_W-1:0] id);
        @(posedge pclk);
        blk_in_valid <= 1'b1;
        blk_in_id <= id;
        @(posedge pclk);
        blk_in_valid <= 1'b0;
    endtask

    // Waits until the channel has been quiet for a few cycles
    task automatic settle();
        int n;
        int idle;
        n = 0;
        idle = 0;
        while (idle < 4 && n < 300) begin
            @(posedge pclk);
            idle = (tx_busy === 1'b0) ? idle + 1 : 0;
            n++;
        end
        if (n >= 300)
            bad_count++;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        blk_in_valid <= 1'b0;
        blk_in_id <= 16'h0000;
        chan_open <= 1'b0;
        hold <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chan_open <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk(rdata, rows[i].d);
            chk(rerr, rows[i].e);
        end
        apb(1'b1, ADDR_CAPACITY, 32'h3);
        chk(rerr, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h8);
        rd_chk(ADDR_CTRL, 32'h0);
        // Basic method: first block starts while later ones wait
        hold <= 1'b1;
        push(16'h000A);
        push(16'h000B);
        push(16'h000C);
        chk(tx_id, 32'hA);
        rd_chk(ADDR_OCCUPANCY, 32'h2);
        hold <= 1'b0;
        settle();
        exp = '{16'h000A, 16'h000B, 16'h000C};
        // Overflow behind a stalled link
        hold <= 1'b1;
        push(16'h0014);
        for (int k = 21; k <= 29; k++)
            push(16'(k));
        rd_chk(ADDR_OCCUPANCY, 32'h8);
        rd_chk(ADDR_DROPPED, 32'h1);
        hold <= 1'b0;
        settle();
        exp.push_back(16'h0014);
        for (int k = 22; k <= 29; k++)
            exp.push_back(16'(k));
        // Host-driven continuous: nothing leaves before go
        apb(1'b1, ADDR_CTRL, {29'h0, CONTINUOUS_STYLE, HOST_DRIVEN_METHOD});
        push(16'h001E);
        push(16'h001F);
        settle();
        chk(sent.size(), exp.size());
        apb(1'b1, ADDR_CMD, 32'h1);
        settle();
        exp.push_back(16'h001E);
        exp.push_back(16'h001F);
        chk(sent.size(), exp.size());
        hold <= 1'b1;
        push(16'h0020);
        apb(1'b1, ADDR_CMD, 32'h2);
        chk(tx_busy, 1'b1);
        push(16'h0021);
        hold <= 1'b0;
        settle();
        exp.push_back(16'h0020);
        rd_chk(ADDR_OCCUPANCY, 32'h1);
        // Counted burst of two, third block stays queued
        apb(1'b1, ADDR_CTRL, {29'h0, COUNTED_BURST_STYLE, HOST_DRIVEN_METHOD});
        apb(1'b1, ADDR_BLOCKS, 32'h2);
        rd_chk(ADDR_BLOCKS, 32'h2);
        push(16'h0022);
        push(16'h0023);
        apb(1'b1, ADDR_CMD, 32'h1);
        settle();
        exp.push_back(16'h0021);
        exp.push_back(16'h0022);
        rd_chk(ADDR_OCCUPANCY, 32'h1);
        rd_chk(ADDR_STATUS, 32'h0);
        chk(sent.size(), exp.size());
        foreach (exp[i])
            chk({16'h0, sent[i]}, {16'h0, exp[i]});
        // Closing the channel flushes, tally survives
        @(posedge pclk);
        chan_open <= 1'b0;
        repeat (2) @(posedge pclk);
        chan_open <= 1'b1;
        rd_chk(ADDR_OCCUPANCY, 32'h0);
        rd_chk(ADDR_DROPPED, 32'h1);
        // Automatic method: go is ignored and a block leaves at once
        apb(1'b1, ADDR_CTRL, {30'h0, METHOD_AUTOMATIC});
        apb(1'b1, ADDR_CMD, 32'h1);
        rd_chk(ADDR_STATUS, 32'h0);
        push(16'h0030);
        settle();
        exp.push_back(16'h0030);
        chk(sent.size(), exp.size());
        chk({16'h0, sent[sent.size()-1]}, 32'h30);
        // Reserved method code leaves the method alone
        apb(1'b1, ADDR_CTRL, 32'h3);
        rd_chk(ADDR_CTRL, 32'h1);
        // Mid-run reset brings settings and tally back to reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_BLOCKS, 32'h1);
        rd_chk(ADDR_DROPPED, 32'h0);
        rd_chk(ADDR_STATUS, 32'h0);
        end_sim();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(100 * 20000);
        bad_count++;
        end_sim();
    end
endmodule // test_image_block_transfer_queue
